/* logic/acq_fmt_consts.vh */
/*
 acquisition format control constants: setting encodings and reset
 values. assumes inclusion by bare name from design files.
*/
`ifndef ACQ_FMT_CONSTS_VH
`define ACQ_FMT_CONSTS_VH

// setting encodings
`define TYPE_REAL 1'b0
`define TYPE_COMPLEX 1'b1
`define RES_32 1'b0
`define RES_16 1'b1
`define MODE_BLOCK 1'b0
`define MODE_CONT 1'b1

// reset values
`define BLOCK_LEN_RST 16'h0100
`define FMT_CNT_RST 16'h0000
`endif

/* logic/acq_buf2.v */
/*
 two-entry buffer with valid/ready on both sides.
 assumes a single clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
module acq_buf2
#(
	parameter WIDTH = 32
)
(
	// clock and reset
	input wire i_ref_clk,
	input wire i_nrst,
	// fill side
	input wire i_in_valid,
	output wire o_in_ready,
	input wire [WIDTH-1:0] i_in_data,
	// drain side
	output wire o_out_valid,
	input wire i_out_ready,
	output wire [WIDTH-1:0] o_out_data
);
	reg [WIDTH-1:0] mem_r [0:1];
	reg wp_r;
	reg rp_r;
	reg [1:0] cnt_r;
	wire push;
	wire pop;

	// honest full and empty from the entry count
	assign o_in_ready = (cnt_r != 2'h2);
	assign o_out_valid = (cnt_r != 2'h0);
	assign o_out_data = mem_r[rp_r];
	assign push = i_in_valid & o_in_ready;
	assign pop = o_out_valid & i_out_ready;

	// storage and pointers
	always @(posedge i_ref_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			wp_r <= 1'b0;
			rp_r <= 1'b0;
			cnt_r <= 2'h0;
			mem_r[0] <= {WIDTH{1'b0}};
			mem_r[1] <= {WIDTH{1'b0}};
		end
		else
		begin
			if (push)
			begin
				mem_r[wp_r] <= i_in_data;
				wp_r <= ~wp_r;
			end
			if (pop)
				rp_r <= ~rp_r;
			if (push & ~pop)
				cnt_r <= cnt_r + 2'h1;
			else if (pop & ~push)
				cnt_r <= cnt_r - 2'h1;
		end
	end
endmodule // acq_buf2

/* logic/acq_fmt_ctrl.v */
/*
 acquisition format and collection mode control: turns arm/trigger and
 incoming samples into a formatted word stream toward the output fifo.
 assumes samples arrive from logic on i_ref_clk; arm and trigger are pins
 and are synchronised; the fifo reports space through i_fifo_ready.
*/
`timescale 1ns/1ps
`include "acq_fmt_consts.vh"
module acq_fmt_ctrl
#(
	parameter BLEN_W = 16
)
(
	// clock and reset
	input wire i_ref_clk,
	input wire i_nrst,
	// settings, held steady while a measurement runs
	input wire i_type,
	input wire i_res,
	input wire i_mode,
	input wire [BLEN_W-1:0] i_block_len,
	// arm, trigger and overflow clear (pins)
	input wire i_arm,
	input wire i_trig,
	input wire i_ovf_clr,
	// samples from the filter chain
	input wire i_smp_valid,
	input wire [31:0] i_smp_re,
	input wire [31:0] i_smp_im,
	// word stream toward the output fifo
	output wire o_word_valid,
	input wire i_fifo_ready,
	output wire [31:0] o_word,
	output wire o_word_16,
	output wire o_block_end,
	// status
	output wire o_running,
	output wire o_armed,
	output wire o_block_done,
	output wire o_ovf
);
	// collection states, binary coded
	localparam [1:0] S_IDLE = 2'h0;
	localparam [1:0] S_ARMED = 2'h1;
	localparam [1:0] S_RUN = 2'h2;

	reg [1:0] arm_s_r;
	reg [1:0] trig_s_r;
	reg [1:0] clr_s_r;
	reg arm_d_r;
	reg trig_d_r;
	reg [1:0] st_r;
	reg [1:0] st_nxt;
	reg [BLEN_W-1:0] cnt_r;
	reg ovf_r;
	reg done_r;
	reg im_pend_r;
	reg [31:0] im_r;
	reg last_r;
	wire arm_p;
	wire trig_p;
	wire b_in_ready;
	wire b_in_valid;
	wire [33:0] b_in_data;
	wire [33:0] b_out_data;
	wire take;
	wire last_smp;
	wire [31:0] re_fmt;
	wire [31:0] im_fmt;
	wire ovf_evt;

	////////////////////////////////////////////////////////////////////
	// pin synchronisers and edge detect on second stage only
	always @(posedge i_ref_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			arm_s_r <= 2'h0;
			trig_s_r <= 2'h0;
			clr_s_r <= 2'h0;
			arm_d_r <= 1'b0;
			trig_d_r <= 1'b0;
		end
		else
		begin
			arm_s_r <= {arm_s_r[0], i_arm};
			trig_s_r <= {trig_s_r[0], i_trig};
			clr_s_r <= {clr_s_r[0], i_ovf_clr};
			arm_d_r <= arm_s_r[1];
			trig_d_r <= trig_s_r[1];
		end
	end
	assign arm_p = arm_s_r[1] & ~arm_d_r;
	assign trig_p = trig_s_r[1] & ~trig_d_r;

	////////////////////////////////////////////////////////////////////
	// sample formatting: 16-bit mode keeps the low half, zero-extended
	assign re_fmt = (i_res == `RES_16) ? {16'h0000, i_smp_re[15:0]}
		: i_smp_re;
	assign im_fmt = (i_res == `RES_16) ? {16'h0000, i_smp_im[15:0]}
		: i_smp_im;

	// a sample is taken while running, no imaginary word is pending and
	// the buffer has room; a sample it cannot hold is never counted
	assign take = (st_r == S_RUN) & i_smp_valid & ~im_pend_r & b_in_ready;
	assign last_smp = (cnt_r == i_block_len - {{(BLEN_W-1){1'b0}}, 1'b1});
	// sample lost because the fifo path has no room
	assign ovf_evt = (st_r == S_RUN) & i_smp_valid &
		(~b_in_ready | im_pend_r);

	// buffer input: real word first, then a pending imaginary word
	assign b_in_valid = im_pend_r | take;
	assign b_in_data = im_pend_r ? {last_r, i_res, im_r}
		: {(last_smp & (i_type == `TYPE_REAL)), i_res, re_fmt};

	////////////////////////////////////////////////////////////////////
	// collection state machine
	always @*
	begin
		st_nxt = st_r;
		case (st_r)
		S_IDLE:
			if (arm_p)
				st_nxt = S_ARMED;
		S_ARMED:
			if (trig_p)
				st_nxt = S_RUN;
		S_RUN:
			if (ovf_evt & (i_mode == `MODE_CONT))
				st_nxt = S_IDLE;
			else if (take & last_smp & (i_mode == `MODE_BLOCK))
				st_nxt = S_IDLE;
		default:
			st_nxt = S_IDLE;
		endcase
	end

	// state, block counter and imaginary holding word
	always @(posedge i_ref_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			st_r <= S_IDLE;
			cnt_r <= {BLEN_W{1'b0}};
			im_pend_r <= 1'b0;
			im_r <= 32'h00000000;
			last_r <= 1'b0;
		end
		else
		begin
			st_r <= st_nxt;
			if (st_r == S_ARMED && trig_p)
				cnt_r <= {BLEN_W{1'b0}};
			else if (take)
				cnt_r <= last_smp ? {BLEN_W{1'b0}}
					: cnt_r + {{(BLEN_W-1){1'b0}}, 1'b1};
			// complex: hold imaginary part until buffer takes it
			if (take & (i_type == `TYPE_COMPLEX))
			begin
				im_pend_r <= 1'b1;
				im_r <= im_fmt;
				last_r <= last_smp;
			end
			else if (im_pend_r & b_in_ready)
				im_pend_r <= 1'b0;
		end
	end

	// sticky flags; a set in the same cycle as a clear wins, so an
	// overflow that races the last synchronised cycle of the host's clear is kept
	always @(posedge i_ref_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			ovf_r <= 1'b0;
			done_r <= 1'b0;
		end
		else
		begin
			// overflow only counts while running continuously
			if (ovf_evt & (i_mode == `MODE_CONT))
				ovf_r <= 1'b1;
			else if (clr_s_r[1])
				ovf_r <= 1'b0;
			// block done: set by block end, cleared on arm
			if (take & last_smp)
				done_r <= 1'b1;
			else if (arm_p)
				done_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// two-entry buffer so a fifo stall drops no word
	acq_buf2 #(.WIDTH(34)) u_buf
	(
		.i_ref_clk(i_ref_clk),
		.i_nrst(i_nrst),
		.i_in_valid(b_in_valid),
		.o_in_ready(b_in_ready),
		.i_in_data(b_in_data),
		.o_out_valid(o_word_valid),
		.i_out_ready(i_fifo_ready),
		.o_out_data(b_out_data)
	);

	// outputs
	assign o_word = b_out_data[31:0];
	assign o_word_16 = b_out_data[32];
	assign o_block_end = b_out_data[33];
	assign o_running = (st_r == S_RUN);
	assign o_armed = (st_r == S_ARMED);
	assign o_block_done = done_r;
	assign o_ovf = ovf_r;
endmodule // acq_fmt_ctrl

/* test/acq_fmt_ctrl_assertions.sv */
/* port checker for acq_fmt_ctrl.
 assumes one clock and the active-low async reset. */
`timescale 1ns/1ps
module acq_fmt_ctrl_assertions
(
	// watched ports
	input wire i_ref_clk,
	input wire i_nrst,
	input wire i_res,
	input wire i_mode,
	input wire i_ovf_clr,
	input wire i_fifo_ready,
	input wire o_word_valid,
	input wire [31:0] o_word,
	input wire o_word_16,
	input wire o_running,
	input wire o_armed,
	input wire o_block_done,
	input wire o_ovf
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_nrst);

	// a stalled word must stay put
	sequence s_stall;
		o_word_valid && !i_fifo_ready;
	endsequence

	// stalled word neither lost nor changed
	chk_word_held: assert property (
		s_stall |=> o_word_valid && $stable(o_word))
		else $error("word lost in stall");
	// width flag follows the resolution setting
	chk_res_flag: assert property (
		o_word_valid |-> o_word_16 == i_res)
		else $error("word width flag wrong");
	// short words carry nothing in the upper half
	chk_upper_zero: assert property (
		o_word_valid && o_word_16 |-> o_word[31:16] == 16'h0000)
		else $error("short word upper half set");
	// block mode stops at the block end
	chk_block_halt: assert property (
		$rose(o_block_done) && !i_mode |-> ##[0:1] !o_running)
		else $error("block mode kept running");
	// a run only starts from the armed state
	chk_run_armed: assert property (
		$rose(o_running) |-> $past(o_armed))
		else $error("run without arm");
	// continuous run only ends by overflow
	chk_cont_run: assert property (
		o_running && i_mode |=> o_running || o_ovf)
		else $error("continuous run stopped");
	// overflow leaves the run stopped
	chk_ovf_stop: assert property (
		$rose(o_ovf) |-> i_mode ##1 !o_running)
		else $error("overflow did not stop run");
	// the clear pin reaches the flag three edges late through its synchroniser
	chk_ovf_sticky: assert property (
		o_ovf && !$past(i_ovf_clr) |=> o_ovf)
		else $error("overflow flag not sticky");
endmodule // acq_fmt_ctrl_assertions
bind acq_fmt_ctrl acq_fmt_ctrl_assertions i_chk (.i_ref_clk, .i_nrst,
	.i_res, .i_mode, .i_ovf_clr, .i_fifo_ready, .o_word_valid, .o_word,
	.o_word_16, .o_running, .o_armed, .o_block_done, .o_ovf);

/* test/fifo_reader_model.sv */
/* output fifo reader: takes words unless stalled.
 assumes the word stream ports of acq_fmt_ctrl. */
`timescale 1ns/1ps
module fifo_reader_model
(
	// clock, reset, stall
	input wire i_ref_clk,
	input wire i_nrst,
	input wire i_stall,
	// word stream
	input wire i_valid,
	input wire [31:0] i_word,
	input wire i_end,
	output wire o_ready,
	// counts of taken words and of block ends
	output int o_n,
	output int o_ends
);
// last sixteen taken words, read by the bench
logic [31:0] log_w [0:15];
// drain promptly unless told to stall
assign o_ready = !i_stall;
// log each taken word
always @(posedge i_ref_clk or negedge i_nrst)
	if (!i_nrst)
	begin
		o_n <= 0;
		o_ends <= 0;
	end
	else if (i_valid && o_ready)
	begin
		log_w[o_n[3:0]] <= i_word;
		o_n <= o_n + 1;
		o_ends <= o_ends + i_end;
	end
endmodule // fifo_reader_model

/* test/acq_fmt_ctrl_tb_top.sv */
/* bench for acq_fmt_ctrl with the fifo reader model.
 assumes design, checker and model compiled first. */
`timescale 1ns/1ps
module acq_fmt_ctrl_tb_top;
logic clk = 0, nrst = 0, typ = 0, res = 0, mode = 0, arm = 0, trig = 0;
logic clr = 0, sv = 0, stall = 0, rdy, wv, run, armd, bd, ovf, bend;
logic [15:0] blen = 16'h0002;
logic [31:0] re = 0, im = 0, wd, e0, e1, ex;
logic [65:0] rows [0:3] = '{{2'h0, 32'h12345678, 32'h0},
	{2'h1, 32'h00005678, 32'h0}, {2'h2, 32'h12345678, 32'h9abcdef0},
	{2'h3, 32'h00005678, 32'h0000def0}};
int n, n0, ne, ne0, mismatches = 0, check_count = 0;
acq_fmt_ctrl i_dut (.i_ref_clk(clk), .i_nrst(nrst), .i_type(typ),
	.i_res(res), .i_mode(mode), .i_block_len(blen), .i_arm(arm),
	.i_trig(trig), .i_ovf_clr(clr), .i_smp_valid(sv), .i_smp_re(re),
	.i_smp_im(im), .o_word_valid(wv), .i_fifo_ready(rdy), .o_word(wd),
	.o_word_16(), .o_block_end(bend), .o_running(run), .o_armed(armd),
	.o_block_done(bd), .o_ovf(ovf));
fifo_reader_model i_rd (.i_ref_clk(clk), .i_nrst(nrst), .i_stall(stall),
	.i_valid(wv), .i_word(wd), .i_end(bend), .o_ready(rdy), .o_n(n),
	.o_ends(ne));
task chk(input logic [31:0] s, e, input string nm);
	check_count++;
	if (s !== e)
	begin
		mismatches++;
		$display("Error %s expected %h seen %h", nm, e, s);
	end
endtask
task test_done;
	$display("checks %0d mismatches %0d", check_count, mismatches);
	if (mismatches == 0 && check_count > 0)
		$display("[ PASS ]");
	else
		$display("[ FAIL ]");
	$finish;
endtask
// arm, then trigger, each seen after sync
task go;
	arm <= 1;
	repeat (2) @(posedge clk);
	arm <= 0;
	repeat (5) @(posedge clk);
	trig <= 1;
	repeat (2) @(posedge clk);
	trig <= 0;
	repeat (5) @(posedge clk);
endtask
task smp;
	re <= 32'h12345678;
	im <= 32'h9abcdef0;
	sv <= 1;
	@(posedge clk);
	sv <= 0;
	repeat (2) @(posedge clk);
endtask
// clock and watchdog
initial forever #25 clk = ~clk;
initial
begin
	#100us;
	mismatches++;
	test_done();
end
// main sequence
initial
begin
	repeat (3) @(posedge clk);
	nrst <= 1;
	for (int r = 0; r < 4; r++)
	begin
		{typ, res, e0, e1} <= rows[r];
		n0 = n;
		ne0 = ne;
		go();
		repeat (3) smp();
		repeat (4) @(posedge clk);
		chk(n - n0, 2 * (typ + 1), "count");
		chk(ne - ne0, 1, "block end");
		for (int k = 0; k < 2 * (typ + 1); k++)
		begin
			ex = (typ && k % 2) ? e1 : e0;
			chk(i_rd.log_w[(n0 + k) % 16], ex, "word");
		end
		chk({bd, run}, 2'b10, "done");
		$display("row %0d done", r);
	end
	{mode, typ, res, blen} <= {3'h4, 16'h0001};
	n0 = n;
	ne0 = ne;
	go();
	repeat (4) smp();
	repeat (4) @(posedge clk);
	chk(n - n0, 4, "cont words");
	chk(ne - ne0, 4, "cont ends");
	chk(run, 1, "cont run");
	stall <= 1;
	sv <= 1;
	repeat (4) @(posedge clk);
	sv <= 0;
	repeat (2) @(posedge clk);
	chk({ovf, run}, 2'b10, "ovf");
	{stall, clr} <= 2'h1;
	repeat (5) @(posedge clk);
	clr <= 0;
	repeat (2) @(posedge clk);
	chk({ovf, wv}, 0, "ovf clr");
	$display("overflow done");
	go();
	nrst <= 0;
	@(posedge clk);
	nrst <= 1;
	smp();
	repeat (3) @(posedge clk);
	chk(n, 0, "no rearm");
	$display("reset done");
	test_done();
end
endmodule // acq_fmt_ctrl_tb_top
